// File: tcs_pin_if.sv
// Purpose: carries one filtered pin between synchroniser and user
// Assumes: pin is asynchronous to clk_i
// Notes:   level, rise and fall are registered in the synchroniser
`default_nettype none

interface tcs_pin_if;
    logic pin;
    logic level;
    logic rise;
    logic fall;

    modport sync (input pin, output level, output rise, output fall);
    modport user (output pin, input level, input rise, input fall);
endinterface

`default_nettype wire

// File: tcs_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter and edges
// Assumes: synchronous active-high reset
// Notes:   a change is taken once stages two and three agree
`default_nettype none

module tcs_pin_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin
    tcs_pin_if.sync   pins
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } tcs_sync_s;

    tcs_sync_s st_ff;
    tcs_sync_s nxt_st;

    always_comb
    begin
        nxt_st    = st_ff;
        nxt_st.s1 = pins.pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // glitch shorter than the agreement window never reaches level
        if (st_ff.s2 == st_ff.s3)
        begin
            nxt_st.level = st_ff.s2;
        end
        nxt_st.rise = nxt_st.level & ~st_ff.level;
        nxt_st.fall = ~nxt_st.level & st_ff.level;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pins.level = st_ff.level;
    assign pins.rise  = st_ff.rise;
    assign pins.fall  = st_ff.fall;

endmodule // tcs_pin_sync

`default_nettype wire

// File: tcs_pkg.sv
// Purpose: shared constants and types of the timer clock select block
// Assumes: 8-bit registers on the low lane of a 32-bit bus
// Notes:   two channels, each with a window of five word registers
`default_nettype none

package tcs_pkg;

    localparam int unsigned CH_NUM = 2;
    localparam int unsigned PRE_W  = 13;
    localparam int unsigned TAP_W  = 4;

    // byte address layout: bit 5 picks the channel, 4..2 the register
    localparam int unsigned ADR_W   = 6;
    localparam int unsigned CH_BIT  = 5;
    localparam int unsigned IDX_MSB = 4;
    localparam int unsigned IDX_LSB = 2;

    localparam logic [2:0] IDX_MAIN   = 3'h0;
    localparam logic [2:0] IDX_CLKRST = 3'h1;
    localparam logic [2:0] IDX_COUNT  = 3'h2;
    localparam logic [2:0] IDX_CMPA   = 3'h3;
    localparam logic [2:0] IDX_CMPB   = 3'h4;

    localparam logic [7:0] MAIN_RST     = 8'h00;
    localparam logic [7:0] CLKRST_RST   = 8'h00;
    localparam logic [7:0] COUNT_RST    = 8'h00;
    localparam logic [7:0] CMP_RST      = 8'hFF;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] CLKRST_WMASK = 8'h0B;

    // main control fields
    localparam int unsigned CKS_LSB = 0;
    localparam int unsigned CKS_MSB = 2;
    localparam int unsigned CLR_LSB = 3;
    localparam int unsigned CLR_MSB = 4;

    // clock/reset control fields
    localparam int unsigned RIS_BIT   = 3;
    localparam int unsigned EDGE_BIT  = 1;
    localparam int unsigned RATIO_BIT = 0;

    // prescaler bit whose period is the named division
    localparam logic [3:0] TAP_DIV2    = 4'h0;
    localparam logic [3:0] TAP_DIV8    = 4'h2;
    localparam logic [3:0] TAP_DIV32   = 4'h4;
    localparam logic [3:0] TAP_DIV64   = 4'h5;
    localparam logic [3:0] TAP_DIV1024 = 4'h9;
    localparam logic [3:0] TAP_DIV8192 = 4'hC;

    typedef enum logic [2:0] {
        CKS_NONE     = 3'b000,
        CKS_INT_A    = 3'b001,
        CKS_INT_B    = 3'b010,
        CKS_INT_C    = 3'b011,
        CKS_CASCADE  = 3'b100,
        CKS_EXT_RISE = 3'b101,
        CKS_EXT_FALL = 3'b110,
        CKS_EXT_BOTH = 3'b111
    } tcs_cks_e;

    typedef enum logic [1:0] {
        CLR_NONE    = 2'b00,
        CLR_MATCH_A = 2'b01,
        CLR_MATCH_B = 2'b10,
        CLR_EXT     = 2'b11
    } tcs_clr_e;

endpackage

`default_nettype wire

// File: tcs_properties.sv
// Purpose: port-level checks of the timer clock select block
// Assumes: single clock, synchronous active-high reset
// Notes:   configuration is not tracked, so counts are checked loosely
`default_nettype none

module tcs_properties (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // counter state
    input wire logic [7:0]  count0_o,
    input wire logic [7:0]  count1_o,
    input wire logic [1:0]  overflow_o,
    input wire logic [1:0]  match_a_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_clkrst;
        s_take ##0 (!wb_we_i && wb_adr_i[4:2] == tcs_pkg::IDX_CLKRST);
    endsequence
    sequence s_rd_unmapped;
        s_take ##0 (!wb_we_i && wb_adr_i[4:2] > tcs_pkg::IDX_CMPB);
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    property p_ack_after_take;
        s_take |=> s_ack_pulse;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_upper_zero;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
    endproperty
    property p_rsvd_hi;
        s_rd_clkrst |=> wb_dat_o[7:4] == 4'h0;
    endproperty
    property p_rsvd_mid;
        s_rd_clkrst |=> !wb_dat_o[2];
    endproperty
    property p_unmapped;
        s_rd_unmapped |=> wb_dat_o == 32'h0000_0000;
    endproperty
    property p_ovf_zero;
        |overflow_o |-> (!overflow_o[0] || count0_o == 8'h00)
            && (!overflow_o[1] || count1_o == 8'h00);
    endproperty
    property p_match_pulse;
        match_a_o[0] |=> !match_a_o[0];
    endproperty
    // checked through reset too, so the default disable is overridden
    property p_rst_quiet;
        disable iff (1'b0) rst_i |=> !wb_ack_o && count0_o == 8'h00
            && count1_o == 8'h00 && overflow_o == 2'b00;
    endproperty

    a_ack_after_take: assert property (p_ack_after_take)
        else $error("ack missing or longer than one cycle");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data upper bits not zero");
    a_rsvd_hi: assert property (p_rsvd_hi)
        else $error("reserved high bits read nonzero");
    a_rsvd_mid: assert property (p_rsvd_mid)
        else $error("reserved bit two read nonzero");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read nonzero");
    a_ovf_zero: assert property (p_ovf_zero)
        else $error("overflow pulse without wrap to zero");
    a_match_pulse: assert property (p_match_pulse)
        else $error("match pulse longer than one cycle");
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("state not cleared by reset");
endmodule // tcs_properties

bind tcs_top tcs_properties i_tcs_properties (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .count0_o, .count1_o, .overflow_o, .match_a_o
);

`default_nettype wire

// File: tcs_top.sv
// Purpose: clock source and counter clear select for two 8-bit timers
// Assumes: classic Wishbone slave, 40 MHz clk_i, synchronous reset
// Notes:   channels can cascade; external pins pass a 3-stage filter
//
// The Wishbone register port and the address map were decided locally.
`default_nettype none

module tcs_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // external pins, one per channel
    input  wire logic [1:0]  ext_clk_i,
    input  wire logic [1:0]  ext_rst_i,
    // counter state
    output logic      [7:0]  count0_o,
    output logic      [7:0]  count1_o,
    output logic      [1:0]  overflow_o,
    output logic      [1:0]  match_a_o,
    output logic      [1:0]  match_b_o
);

    typedef struct packed {
        logic [tcs_pkg::PRE_W-1:0] pre;
        logic [1:0][7:0]           main;
        logic [1:0][7:0]           clkrst;
        logic [1:0][7:0]           count;
        logic [1:0][7:0]           cmpa;
        logic [1:0][7:0]           cmpb;
        logic [1:0]                ovf;
        logic [1:0]                mta;
        logic [1:0]                mtb;
        logic                      ack;
        logic [31:0]               dat;
    } tcs_top_s;

    localparam tcs_top_s ST_RST = '{
        pre:    '0,
        main:   {2{tcs_pkg::MAIN_RST}},
        clkrst: {2{tcs_pkg::CLKRST_RST}},
        count:  {2{tcs_pkg::COUNT_RST}},
        cmpa:   {2{tcs_pkg::CMP_RST}},
        cmpb:   {2{tcs_pkg::CMP_RST}},
        ovf:    '0,
        mta:    '0,
        mtb:    '0,
        ack:    1'b0,
        dat:    '0
    };

    tcs_top_s st_ff;
    tcs_top_s nxt_st;

    logic [1:0] clk_rise;
    logic [1:0] clk_fall;
    logic [1:0] rst_level;
    logic [1:0] rst_rise;

    // prescaler bit for an internal mode and ratio select
    function automatic logic [tcs_pkg::TAP_W-1:0] tap_index(
        input tcs_pkg::tcs_cks_e cks,
        input logic              ratio
    );
        logic [tcs_pkg::TAP_W-1:0] t;
        t = tcs_pkg::TAP_DIV8;
        case (cks)
            tcs_pkg::CKS_INT_A:
                t = ratio ? tcs_pkg::TAP_DIV2 : tcs_pkg::TAP_DIV8;
            tcs_pkg::CKS_INT_B:
                t = ratio ? tcs_pkg::TAP_DIV32 : tcs_pkg::TAP_DIV64;
            tcs_pkg::CKS_INT_C:
                t = ratio ? tcs_pkg::TAP_DIV1024
                          : tcs_pkg::TAP_DIV8192;
            default:
                t = tcs_pkg::TAP_DIV8;
        endcase
        return t;
    endfunction

    // read value of one register; unmapped words read zero
    function automatic logic [7:0] read_reg(
        input tcs_top_s   s,
        input logic       c,
        input logic [2:0] i
    );
        logic [7:0] v;
        v = 8'h00;
        case (i)
            tcs_pkg::IDX_MAIN:   v = s.main[c];
            tcs_pkg::IDX_CLKRST: v = s.clkrst[c];
            tcs_pkg::IDX_COUNT:  v = s.count[c];
            tcs_pkg::IDX_CMPA:   v = s.cmpa[c];
            tcs_pkg::IDX_CMPB:   v = s.cmpb[c];
            default:             v = 8'h00;
        endcase
        return v;
    endfunction

    genvar g;
    generate
        for (g = 0; g < tcs_pkg::CH_NUM; g++)
        begin : g_pin
            tcs_pin_if u_clk_if ();
            tcs_pin_if u_rst_if ();

            assign u_clk_if.pin = ext_clk_i[g];
            assign u_rst_if.pin = ext_rst_i[g];
            assign clk_rise[g]  = u_clk_if.rise;
            assign clk_fall[g]  = u_clk_if.fall;
            assign rst_level[g] = u_rst_if.level;
            assign rst_rise[g]  = u_rst_if.rise;

            tcs_pin_sync u_clk_sync (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .pins  (u_clk_if)
            );

            tcs_pin_sync u_rst_sync (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .pins  (u_rst_if)
            );
        end
    endgenerate

    always_comb
    begin
        logic [tcs_pkg::PRE_W-1:0] pre_nxt;
        logic [tcs_pkg::PRE_W-1:0] rise_vec;
        logic [tcs_pkg::PRE_W-1:0] fall_vec;
        logic                      req;
        logic                      wr;
        logic                      ch;
        logic [2:0]                idx;
        tcs_pkg::tcs_cks_e         cks;
        tcs_pkg::tcs_clr_e         clr;
        logic [tcs_pkg::TAP_W-1:0] tap;
        logic                      tick;
        logic                      clear;
        logic                      wr_cnt;
        logic [7:0]                cnt;

        pre_nxt  = '0;
        rise_vec = '0;
        req      = 1'b0;
        wr       = 1'b0;
        ch       = 1'b0;
        idx      = '0;
        fall_vec = '0;
        cks      = tcs_pkg::CKS_NONE;
        clr      = tcs_pkg::CLR_NONE;
        tap      = '0;
        tick     = 1'b0;
        clear    = 1'b0;
        wr_cnt   = 1'b0;
        cnt      = '0;
        nxt_st   = st_ff;

        // free-running prescaler; its bit edges are the internal clocks
        pre_nxt    = st_ff.pre + 1'b1;
        nxt_st.pre = pre_nxt;
        rise_vec   = pre_nxt & ~st_ff.pre;
        fall_vec   = ~pre_nxt & st_ff.pre;

        req = wb_cyc_i & wb_stb_i;
        ch  = wb_adr_i[tcs_pkg::CH_BIT];
        idx = wb_adr_i[tcs_pkg::IDX_MSB:tcs_pkg::IDX_LSB];
        // write lands on the edge where the master samples ack
        wr  = req & st_ff.ack & wb_we_i & wb_sel_i[0];

        nxt_st.ack = req & ~st_ff.ack;
        if (req & ~st_ff.ack)
        begin
            nxt_st.dat = {24'h00_0000, read_reg(st_ff, ch, idx)};
        end

        for (int c = 0; c < tcs_pkg::CH_NUM; c++)
        begin
            cks = tcs_pkg::tcs_cks_e'(
                st_ff.main[c][tcs_pkg::CKS_MSB:tcs_pkg::CKS_LSB]);
            clr = tcs_pkg::tcs_clr_e'(
                st_ff.main[c][tcs_pkg::CLR_MSB:tcs_pkg::CLR_LSB]);
            tap = tap_index(cks, st_ff.clkrst[c][tcs_pkg::RATIO_BIT]);

            case (cks)
                tcs_pkg::CKS_INT_A,
                tcs_pkg::CKS_INT_B,
                tcs_pkg::CKS_INT_C:
                    tick = st_ff.clkrst[c][tcs_pkg::EDGE_BIT]
                         ? fall_vec[tap] : rise_vec[tap];
                tcs_pkg::CKS_CASCADE:
                begin
                    // a mutual cascade ticks only after a write or clear lands channel zero's count on compare A: both wait on the other
                    if (c == 0)
                    begin
                        tick = st_ff.ovf[1];
                    end
                    else
                    begin
                        tick = st_ff.mta[0];
                    end
                end
                tcs_pkg::CKS_EXT_RISE:
                    tick = clk_rise[c];
                tcs_pkg::CKS_EXT_FALL:
                    tick = clk_fall[c];
                tcs_pkg::CKS_EXT_BOTH:
                    tick = clk_rise[c] | clk_fall[c];
                default:
                    tick = 1'b0;
            endcase

            case (clr)
                tcs_pkg::CLR_MATCH_A:
                    clear = st_ff.count[c] == st_ff.cmpa[c];
                tcs_pkg::CLR_MATCH_B:
                    clear = st_ff.count[c] == st_ff.cmpb[c];
                tcs_pkg::CLR_EXT:
                begin
                    if (st_ff.clkrst[c][tcs_pkg::RIS_BIT])
                    begin
                        clear = rst_level[c];
                    end
                    else
                    begin
                        clear = rst_rise[c];
                    end
                end
                default:
                    clear = 1'b0;
            endcase

            wr_cnt = wr && (ch == 1'(c)) && (idx == tcs_pkg::IDX_COUNT);

            // software write beats clear, clear beats a count
            if (wr_cnt)
            begin
                cnt = wb_dat_i[7:0];
            end
            else if (clear)
            begin
                cnt = tcs_pkg::COUNT_RST;
            end
            else if (tick)
            begin
                cnt = st_ff.count[c] + 8'h01;
            end
            else
            begin
                cnt = st_ff.count[c];
            end
            nxt_st.count[c] = cnt;

            nxt_st.ovf[c] = tick & ~clear & ~wr_cnt
                          & (st_ff.count[c] == tcs_pkg::COUNT_MAX);
            nxt_st.mta[c] = (cnt != st_ff.count[c])
                          & (cnt == st_ff.cmpa[c]);
            nxt_st.mtb[c] = (cnt != st_ff.count[c])
                          & (cnt == st_ff.cmpb[c]);

            if (wr && (ch == 1'(c)))
            begin
                case (idx)
                    tcs_pkg::IDX_MAIN:
                        nxt_st.main[c] = wb_dat_i[7:0];
                    tcs_pkg::IDX_CLKRST:
                    begin
                        // reserved bits never store, so they read zero
                        nxt_st.clkrst[c] = wb_dat_i[7:0]
                                         & tcs_pkg::CLKRST_WMASK;
                    end
                    tcs_pkg::IDX_CMPA:
                        nxt_st.cmpa[c] = wb_dat_i[7:0];
                    tcs_pkg::IDX_CMPB:
                        nxt_st.cmpb[c] = wb_dat_i[7:0];
                    default:
                        nxt_st.cmpb[c] = st_ff.cmpb[c];
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= ST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_o   = st_ff.ack;
    assign wb_dat_o   = st_ff.dat;
    assign count0_o   = st_ff.count[0];
    assign count1_o   = st_ff.count[1];
    assign overflow_o = st_ff.ovf;
    assign match_a_o  = st_ff.mta;
    assign match_b_o  = st_ff.mtb;

endmodule // tcs_top

`default_nettype wire

// File: tcs_top_test.sv
// Purpose: self-checking bench for the timer clock select block
// Assumes: bus answers one cycle after a request is taken
// Notes:   rates are timed between two successive count changes
`default_nettype none

module tcs_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [5:0]  wb_adr_i = 6'h00;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  ext_clk_i = 2'b00;
    logic [1:0]  ext_rst_i = 2'b00;
    logic [7:0]  count0_o;
    logic [7:0]  count1_o;
    logic [1:0]  overflow_o;
    logic [1:0]  match_a_o;
    logic [1:0]  match_b_o;
    logic [7:0]  mx;
    logic        seen;
    int          err_total = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [7:0]  rt_main [7] = '{8'h01, 8'h01, 8'h01, 8'h02, 8'h02,
                                 8'h03, 8'h03};
    logic [7:0]  rt_ctl [7] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h03,
                                8'h00, 8'h01};
    logic [15:0] rt_div [7] = '{16'h0008, 16'h0002, 16'h0008, 16'h0040,
                                16'h0020, 16'h2000, 16'h0400};

    tcs_top i_tcs_top (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_clk_i,
        .ext_rst_i, .count0_o, .count1_o, .overflow_o, .match_a_o,
        .match_b_o
    );

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic bus(input logic ch, input logic [2:0] idx,
                       input logic we, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {ch, idx, 2'b00};
        wb_dat_i <= {24'h00_0000, wd};
        // no cycle limit here: the bench-wide timeout ends a hung access
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic ch, input logic [2:0] idx,
                      input logic [7:0] d);
        logic [7:0] r;
        bus(ch, idx, 1'b1, d, r);
    endtask

    task automatic rd_chk(input logic ch, input logic [2:0] idx,
                          input logic [7:0] exp);
        logic [7:0] r;
        bus(ch, idx, 1'b0, 8'h00, r);
        chk({8'h00, r}, {8'h00, exp});
    endtask

    // drives channel zero's clock pin (1) or clear pin (0), then waits
    // past the pin filter
    task automatic pin(input logic clk_pin, input logic v);
        @(posedge clk_i);
        if (clk_pin)
            ext_clk_i[0] <= v;
        else
            ext_rst_i[0] <= v;
        repeat (12) @(posedge clk_i);
    endtask

    function automatic logic [7:0] cnt(input logic ch);
        return ch ? count1_o : count0_o;
    endfunction

    task automatic period(input logic ch, input logic [15:0] div);
        logic [7:0] c;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_i);
            c = cnt(ch);
            n = 1;
            while (cnt(ch) === c && n < 20000)
            begin
                @(posedge clk_i);
                n++;
            end
        end
        chk(n[15:0], div);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            err_total++;
            close_out();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(0, tcs_pkg::IDX_MAIN, 8'h00);
        rd_chk(0, tcs_pkg::IDX_CLKRST, 8'h00);
        rd_chk(1, tcs_pkg::IDX_CMPA, 8'hFF);
        rd_chk(1, tcs_pkg::IDX_CMPB, 8'hFF);
        wr(0, tcs_pkg::IDX_CLKRST, 8'hFF);
        rd_chk(0, tcs_pkg::IDX_CLKRST, 8'h0B);
        wr(1, 3'h5, 8'hAA);
        rd_chk(1, 3'h5, 8'h00);
        wr(0, tcs_pkg::IDX_MAIN, 8'hE0);
        rd_chk(0, tcs_pkg::IDX_MAIN, 8'hE0);
        repeat (200) @(posedge clk_i);
        chk({8'h00, count0_o}, 16'h0000);
        for (int i = 0; i < 7; i++)
        begin
            wr(i[0], tcs_pkg::IDX_MAIN, rt_main[i]);
            wr(i[0], tcs_pkg::IDX_CLKRST, rt_ctl[i]);
            period(i[0], rt_div[i]);
        end
        wr(1, tcs_pkg::IDX_MAIN, 8'h00);
        for (int m = 5; m < 8; m++)
        begin
            wr(0, tcs_pkg::IDX_MAIN, 8'(m));
            wr(0, tcs_pkg::IDX_COUNT, 8'h00);
            pin(1, 1'b1);
            chk({8'h00, count0_o}, {15'h0000, m != 6});
            pin(1, 1'b0);
            chk({8'h00, count0_o}, m == 7 ? 16'h0002 : 16'h0001);
        end
        // overflow of channel one drives channel zero
        wr(0, tcs_pkg::IDX_COUNT, 8'h00);
        wr(0, tcs_pkg::IDX_MAIN, 8'h04);
        wr(1, tcs_pkg::IDX_COUNT, 8'hFE);
        wr(1, tcs_pkg::IDX_CLKRST, 8'h01);
        wr(1, tcs_pkg::IDX_MAIN, 8'h01);
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge clk_i);
            seen = seen | overflow_o[1];
        end
        chk({15'h0000, seen}, 16'h0001);
        chk({8'h00, count0_o}, 16'h0001);
        wr(1, tcs_pkg::IDX_MAIN, 8'h00);
        wr(0, tcs_pkg::IDX_MAIN, 8'h00);
        // match A of channel zero drives channel one
        wr(0, tcs_pkg::IDX_CMPA, 8'h0A);
        wr(0, tcs_pkg::IDX_COUNT, 8'h00);
        wr(1, tcs_pkg::IDX_COUNT, 8'h00);
        wr(1, tcs_pkg::IDX_MAIN, 8'h04);
        wr(0, tcs_pkg::IDX_MAIN, 8'h01);
        seen = 1'b0;
        repeat (30)
        begin
            @(posedge clk_i);
            seen = seen | match_a_o[0];
        end
        chk({15'h0000, seen}, 16'h0001);
        chk({8'h00, count1_o}, 16'h0001);
        wr(1, tcs_pkg::IDX_MAIN, 8'h00);
        for (int c = 0; c < 3; c++)
        begin
            wr(0, tcs_pkg::IDX_MAIN, 8'h00);
            wr(0, tcs_pkg::IDX_CMPA, 8'h05);
            wr(0, tcs_pkg::IDX_CMPB, 8'h09);
            wr(0, tcs_pkg::IDX_COUNT, 8'h00);
            wr(0, tcs_pkg::IDX_MAIN, {3'h0, c[1:0], 3'h1});
            mx = 8'h00;
            seen = 1'b0;
            repeat (60)
            begin
                @(posedge clk_i);
                seen = seen | match_b_o[0];
                if (count0_o > mx)
                    mx = count0_o;
            end
            if (c == 0)
                chk({15'h0000, mx > 8'h09}, 16'h0001);
            else
                chk({8'h00, mx}, c == 1 ? 16'h0005 : 16'h0009);
            // compare B is 9: only the run that stops at 5 never meets it
            chk({15'h0000, seen}, {15'h0000, c != 1});
        end
        wr(0, tcs_pkg::IDX_MAIN, 8'h00);
        wr(0, tcs_pkg::IDX_CLKRST, 8'h08);
        wr(0, tcs_pkg::IDX_COUNT, 8'h55);
        pin(0, 1'b1);
        chk({8'h00, count0_o}, 16'h0055);
        wr(0, tcs_pkg::IDX_MAIN, 8'h18);
        repeat (4) @(posedge clk_i);
        chk({8'h00, count0_o}, 16'h0000);
        wr(0, tcs_pkg::IDX_CLKRST, 8'h00);
        wr(0, tcs_pkg::IDX_COUNT, 8'h55);
        repeat (12) @(posedge clk_i);
        chk({8'h00, count0_o}, 16'h0055);
        pin(0, 1'b0);
        pin(0, 1'b1);
        chk({8'h00, count0_o}, 16'h0000);
        pin(0, 1'b0);
        wr(0, tcs_pkg::IDX_CLKRST, 8'h08);
        wr(0, tcs_pkg::IDX_COUNT, 8'h33);
        repeat (12) @(posedge clk_i);
        chk({8'h00, count0_o}, 16'h0033);
        close_out();
    end
endmodule // tcs_top_test

`default_nettype wire
